/* File: common/aus_pkg.sv */
/*
  Shared constants for the serial transceiver control and status block:
  register offsets, bit positions, reset values and engine states.
  Assumes a 32-bit APB slave with byte addresses on an 8-bit paddr.
*/
package aus_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFF_CTRL_A = 8'h00;
  localparam logic [7:0] OFF_CTRL_B = 8'h04;
  localparam logic [7:0] OFF_CTRL_C = 8'h08;
  localparam logic [7:0] OFF_STAT_A = 8'h0C;
  localparam logic [7:0] OFF_DATA   = 8'h10;
  localparam logic [7:0] OFF_BAUD   = 8'h14;

  ////////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int CA_MODULE_ON = 6, CA_NINE = 4, CA_WAKE = 3, CA_PAR_EN = 1, CA_PAR_ODD = 0;
  localparam int CB_TXE_IE = 7, CB_TXD_IE = 6, CB_RXF_IE = 5, CB_IDLE_IE = 4;
  localparam int CB_TX_ON = 3, CB_RX_ON = 2, CB_STANDBY = 1, CB_SEND_BRK = 0;
  localparam int CC_RX9 = 7, CC_TX9 = 6, CC_OVERRUN_IRQ_EN = 3, CC_NOISE_IRQ_EN = 2, CC_FRAMING_IRQ_EN = 1, CC_PARITY_IRQ_EN = 0;
  localparam int ST_TXE = 7, ST_TXD = 6, ST_RXF = 5, ST_IDLE = 4;
  localparam int ST_OVR = 3, ST_NF = 2, ST_FE = 1, ST_PE = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values and counts
  localparam logic [7:0]  CTRL_A_RST  = 8'h00;
  localparam logic [7:0]  CTRL_B_RST  = 8'h00;
  localparam logic [3:0]  ERR_EN_RST  = 4'h0;
  localparam logic [15:0] BAUD_RST    = 16'h006C;
  localparam logic [15:0] BAUD_MIN    = 16'h0004;
  localparam logic [3:0]  FRAME_BITS8 = 4'hA;
  localparam logic [3:0]  FRAME_BITS9 = 4'hB;

  typedef enum logic [2:0] {TX_IDLE, TX_PRE, TX_BRK, TX_DATA, TX_MARK} aus_tx_e;
  typedef enum logic [0:0] {RX_IDLE, RX_BITS} aus_rx_e;

endpackage

/* File: hw/aus_serial.sv */
/*
  Serial transceiver: APB register file, transmitter with preamble, break and
  data frames, receiver with noise, framing, parity and overrun detection,
  two-step flag clearing and three interrupt request lines.
  Assumes rxd is synchronous to pclk and the bit period register is >= 4.
*/
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module aus_serial (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd,
  output logic             txd,
  output logic             tx_irq_req,
  output logic             rx_irq_req,
  output logic             err_irq_req
);

  logic [7:0]  ctl_a_reg, ctl_b_reg, arm_reg, rx_buf_reg, tx_buf_reg;
  logic [3:0]  err_en_reg, tx_bits_reg, rx_idx_reg, ones_reg;
  logic [15:0] baud_reg, tx_cnt_reg, rx_cnt_reg;
  logic [10:0] tx_sh_reg, rx_sh_reg;
  logic        tx9_reg, rx9_reg, pready_reg, pslverr_reg;
  logic        te_reg, rxf_reg, idle_reg, ovr_reg, nf_reg, fe_reg, pe_reg;
  logic        pend_reg, pre_req_reg, brk_tail_reg, idle_arm_reg;
  logic        smp0_reg, smp1_reg, noise_reg;
  logic [31:0] prdata_reg;
  aus_pkg::aus_tx_e tx_state_reg, tx_kind;
  aus_pkg::aus_rx_e rx_state_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, effects at the edge with pready high
  logic        setup_acc, acc, wr, rd, hit;
  logic [31:0] rd_val;
  logic [7:0]  status;
  logic        module_on, nine, tx_on, rx_on, standby, send_brk, tx_done;

  assign setup_acc = psel & penable & ~pready_reg;
  assign acc       = psel & penable & pready_reg;
  assign wr        = acc & pwrite;
  assign rd        = acc & ~pwrite;
  assign module_on = ctl_a_reg[aus_pkg::CA_MODULE_ON];
  assign nine      = ctl_a_reg[aus_pkg::CA_NINE];
  assign tx_on     = ctl_b_reg[aus_pkg::CB_TX_ON];
  assign rx_on     = ctl_b_reg[aus_pkg::CB_RX_ON];
  assign standby   = ctl_b_reg[aus_pkg::CB_STANDBY];
  assign send_brk  = ctl_b_reg[aus_pkg::CB_SEND_BRK];
  assign status    = {te_reg, tx_done, rxf_reg, idle_reg, ovr_reg, nf_reg, fe_reg, pe_reg};

  always_comb begin
    hit    = 1'b1;
    rd_val = 32'h0000_0000;
    if (paddr == aus_pkg::OFF_CTRL_A) begin
      rd_val[7:0] = ctl_a_reg;
    end else if (paddr == aus_pkg::OFF_CTRL_B) begin
      rd_val[7:0] = ctl_b_reg;
    end else if (paddr == aus_pkg::OFF_CTRL_C) begin
      rd_val[7:0] = {rx9_reg, tx9_reg, 2'b00, err_en_reg};
    end else if (paddr == aus_pkg::OFF_STAT_A) begin
      rd_val[7:0] = status;
    end else if (paddr == aus_pkg::OFF_DATA) begin
      rd_val[7:0] = rx_buf_reg;
    end else if (paddr == aus_pkg::OFF_BAUD) begin
      rd_val[15:0] = baud_reg;
    end else begin
      hit = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg <= setup_acc;
      if (setup_acc) begin
        pslverr_reg <= ~hit;
        prdata_reg  <= pwrite ? 32'h0000_0000 : rd_val;
      end
    end
  end

  assign pready  = pready_reg;
  assign pslverr = pready_reg & pslverr_reg;
  assign prdata  = prdata_reg;

  logic wr_a, wr_b, wr_c, wr_data, rd_stat, rd_data, tx_on_rise, rx_on_rise, brk_fall;
  assign wr_a    = wr & (paddr == aus_pkg::OFF_CTRL_A);
  assign wr_b    = wr & (paddr == aus_pkg::OFF_CTRL_B);
  assign wr_c    = wr & (paddr == aus_pkg::OFF_CTRL_C);
  assign wr_data = wr & (paddr == aus_pkg::OFF_DATA);
  assign rd_stat = rd & (paddr == aus_pkg::OFF_STAT_A);
  assign rd_data = rd & (paddr == aus_pkg::OFF_DATA);
  // enable writes take effect only while the module is on
  assign tx_on_rise = wr_b & module_on & pwdata[aus_pkg::CB_TX_ON] & ~tx_on;
  assign rx_on_rise = wr_b & module_on & pwdata[aus_pkg::CB_RX_ON] & ~rx_on;
  assign brk_fall   = wr_b & ~pwdata[aus_pkg::CB_SEND_BRK] & send_brk;

  ////////////////////////////////////////////////////////////////////////////////
  // control registers
  logic rx_done, rx_accept, rx_msb, idle_evt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_a_reg  <= aus_pkg::CTRL_A_RST;
      ctl_b_reg  <= aus_pkg::CTRL_B_RST;
      err_en_reg <= aus_pkg::ERR_EN_RST;
      tx9_reg    <= 1'b0;
      baud_reg   <= aus_pkg::BAUD_RST;
    end else begin
      if (wr_a) ctl_a_reg <= pwdata[7:0];
      if (wr_b) begin
        ctl_b_reg <= pwdata[7:0];
        if (!module_on) begin
          ctl_b_reg[aus_pkg::CB_TX_ON] <= tx_on;
          ctl_b_reg[aus_pkg::CB_RX_ON] <= rx_on;
        end
      end else if (standby && ((rx_done && rx_msb && ctl_a_reg[aus_pkg::CA_WAKE]) ||
                               (idle_evt && !ctl_a_reg[aus_pkg::CA_WAKE]))) begin
        ctl_b_reg[aus_pkg::CB_STANDBY] <= 1'b0;
      end
      if (wr_c) begin
        tx9_reg    <= pwdata[aus_pkg::CC_TX9];
        err_en_reg <= pwdata[3:0];
      end
      if (wr & (paddr == aus_pkg::OFF_BAUD)) begin
        baud_reg <= (pwdata[15:0] < aus_pkg::BAUD_MIN) ? aus_pkg::BAUD_MIN : pwdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // transmitter
  logic [3:0]  nbits;
  logic [15:0] baud_m1, half;
  logic        tx_tick, tx_start, tx_par;
  logic        tx9_held_reg;
  logic [10:0] tx_frame;

  assign nbits    = nine ? aus_pkg::FRAME_BITS9 : aus_pkg::FRAME_BITS8;
  assign baud_m1  = baud_reg - 16'h0001;
  assign half     = {1'b0, baud_reg[15:1]};
  assign tx_tick  = (tx_cnt_reg == baud_m1);
  assign tx_start = (tx_state_reg == aus_pkg::TX_IDLE) || (tx_tick && tx_bits_reg == 4'h1);
  assign tx_par   = (nine ? ^tx_buf_reg : ^tx_buf_reg[6:0]) ^ ctl_a_reg[aus_pkg::CA_PAR_ODD];
  // ninth bit or parity sits just below the stop bit
  assign tx_frame = nine ?
      {1'b1, (ctl_a_reg[aus_pkg::CA_PAR_EN] ? tx_par : tx9_held_reg), tx_buf_reg, 1'b0} :
      {2'b11, (ctl_a_reg[aus_pkg::CA_PAR_EN] ? tx_par : tx_buf_reg[7]), tx_buf_reg[6:0], 1'b0};

  // break wins; a released break gets its mark bit before any start bit
  always_comb begin
    tx_kind = aus_pkg::TX_IDLE;
    if (tx_on && send_brk) begin
      tx_kind = aus_pkg::TX_BRK;
    end else if (brk_tail_reg) begin
      tx_kind = aus_pkg::TX_MARK;
    end else if (tx_on && pre_req_reg) begin
      tx_kind = aus_pkg::TX_PRE;
    end else if (tx_on && pend_reg) begin
      tx_kind = aus_pkg::TX_DATA;
    end
  end

  assign tx_done = te_reg && tx_state_reg == aus_pkg::TX_IDLE && tx_kind == aus_pkg::TX_IDLE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_reg <= aus_pkg::TX_IDLE;
      tx_sh_reg    <= 11'h7FF;
      tx_bits_reg  <= 4'h0;
      tx_cnt_reg   <= 16'h0000;
    end else if (!module_on) begin
      tx_state_reg <= aus_pkg::TX_IDLE;
      tx_sh_reg    <= 11'h7FF;
      tx_bits_reg  <= 4'h0;
      tx_cnt_reg   <= 16'h0000;
    end else if (tx_start) begin
      // while the module stays on, a character in flight always runs to its last bit first
      tx_cnt_reg   <= 16'h0000;
      tx_state_reg <= tx_kind;
      tx_bits_reg  <= (tx_kind == aus_pkg::TX_MARK) ? 4'h1 :
                      (tx_kind == aus_pkg::TX_IDLE) ? 4'h0 : nbits;
      tx_sh_reg    <= (tx_kind == aus_pkg::TX_DATA) ? tx_frame :
                      (tx_kind == aus_pkg::TX_BRK)  ? 11'h000 : 11'h7FF;
    end else if (tx_tick) begin
      tx_cnt_reg  <= 16'h0000;
      tx_bits_reg <= tx_bits_reg - 4'h1;
      tx_sh_reg   <= {1'b1, tx_sh_reg[10:1]};
    end else begin
      tx_cnt_reg <= tx_cnt_reg + 16'h0001;
    end
  end

  assign txd = tx_sh_reg[0];

  logic launch_data;
  assign launch_data = module_on && tx_start && tx_kind == aus_pkg::TX_DATA;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      te_reg       <= 1'b1;
      pend_reg     <= 1'b0;
      pre_req_reg  <= 1'b0;
      brk_tail_reg <= 1'b0;
      tx_buf_reg   <= 8'h00;
      tx9_held_reg <= 1'b0;
    end else begin
      if (launch_data || !module_on) begin
        te_reg <= 1'b1;
      end else if (wr_data && arm_reg[aus_pkg::ST_TXE]) begin
        te_reg <= 1'b0;
      end
      if (wr_data) begin
        tx_buf_reg   <= pwdata[7:0];
        tx9_held_reg <= tx9_reg;
        pend_reg     <= 1'b1;
      end else if (launch_data || !module_on) begin
        pend_reg <= 1'b0;
      end
      if (tx_on_rise) begin
        pre_req_reg <= 1'b1;
      end else if (tx_start && (tx_kind == aus_pkg::TX_PRE || tx_kind == aus_pkg::TX_BRK)) begin
        pre_req_reg <= 1'b0;
      end
      if (brk_fall) begin
        brk_tail_reg <= 1'b1;
      end else if (tx_start && tx_kind == aus_pkg::TX_MARK) begin
        brk_tail_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // receiver
  logic        bit_now, disagree, last_bit;
  logic [10:0] rx_full_word;
  logic [8:0]  rx_d9;
  logic        rx_stop, rx_par_bad, rx_active;

  assign rx_active    = module_on && rx_on;
  assign bit_now      = (smp0_reg & smp1_reg) | (smp0_reg & rxd) | (smp1_reg & rxd);
  assign disagree     = ~((smp0_reg == smp1_reg) && (smp1_reg == rxd));
  assign last_bit     = (rx_idx_reg == nbits - 4'h1);
  assign rx_done      = rx_active && rx_state_reg == aus_pkg::RX_BITS &&
                        rx_cnt_reg == half + 16'h0001 && last_bit;
  assign rx_full_word = {bit_now, rx_sh_reg[10:1]};
  assign rx_d9        = nine ? rx_full_word[9:1] : {1'b0, rx_full_word[9:2]};
  assign rx_stop      = rx_full_word[10];
  assign rx_msb       = nine ? rx_d9[8] : rx_d9[7];
  assign rx_par_bad   = ctl_a_reg[aus_pkg::CA_PAR_EN] &&
                        ((nine ? ^rx_d9 : ^rx_d9[7:0]) ^ ctl_a_reg[aus_pkg::CA_PAR_ODD]);
  assign idle_evt     = rx_active && rx_state_reg == aus_pkg::RX_IDLE && rxd &&
                        rx_cnt_reg == baud_m1 && ones_reg == nbits - 4'h1;
  assign rx_accept    = !standby || (ctl_a_reg[aus_pkg::CA_WAKE] && rx_msb);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_reg <= aus_pkg::RX_IDLE;
      rx_cnt_reg   <= 16'h0000;
      rx_idx_reg   <= 4'h0;
      rx_sh_reg    <= 11'h000;
      ones_reg     <= 4'h0;
      smp0_reg     <= 1'b1;
      smp1_reg     <= 1'b1;
      noise_reg    <= 1'b0;
    end else if (!rx_active) begin
      rx_state_reg <= aus_pkg::RX_IDLE;
      rx_cnt_reg   <= 16'h0000;
      ones_reg     <= 4'h0;
    end else begin
      case (rx_state_reg)
        aus_pkg::RX_IDLE: begin
          if (!rxd) begin
            rx_state_reg <= aus_pkg::RX_BITS;
            rx_cnt_reg   <= 16'h0001;
            rx_idx_reg   <= 4'h0;
            noise_reg    <= 1'b0;
            ones_reg     <= 4'h0;
          end else if (rx_cnt_reg == baud_m1) begin
            rx_cnt_reg <= 16'h0000;
            if (ones_reg != 4'hF) ones_reg <= ones_reg + 4'h1;
          end else begin
            rx_cnt_reg <= rx_cnt_reg + 16'h0001;
          end
        end
        default: begin
          rx_cnt_reg <= (rx_cnt_reg == baud_m1) ? 16'h0000 : rx_cnt_reg + 16'h0001;
          if (rx_cnt_reg == baud_m1) rx_idx_reg <= rx_idx_reg + 4'h1;
          if (rx_cnt_reg == half - 16'h0001) smp0_reg <= rxd;
          if (rx_cnt_reg == half) smp1_reg <= rxd;
          if (rx_cnt_reg == half + 16'h0001) begin
            // a start bit that reads high again was a glitch
            if (rx_idx_reg == 4'h0 && bit_now) begin
              rx_state_reg <= aus_pkg::RX_IDLE;
              rx_cnt_reg   <= 16'h0000;
            end else begin
              rx_sh_reg <= rx_full_word;
              noise_reg <= noise_reg | disagree;
              if (last_bit) begin
                rx_state_reg <= aus_pkg::RX_IDLE;
                rx_cnt_reg   <= 16'h0000;
              end
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // receive buffer: unaffected by reset
  logic rx_take;
  assign rx_take = rx_done && rx_accept && !rxf_reg;

  always_ff @(posedge pclk) begin
    if (rx_take) begin
      rx_buf_reg <= rx_d9[7:0];
      rx9_reg    <= rx_msb;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // receiver flags: a set in the clearing cycle wins
  logic clr_ok;
  assign clr_ok = rd_data;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_reg      <= 8'h00;
      rxf_reg      <= 1'b0;
      idle_reg     <= 1'b0;
      ovr_reg      <= 1'b0;
      nf_reg       <= 1'b0;
      fe_reg       <= 1'b0;
      pe_reg       <= 1'b0;
      idle_arm_reg <= 1'b0;
    end else begin
      if (rd_stat) begin
        arm_reg <= prdata_reg[7:0];
      end else if (rd_data || wr_data) begin
        arm_reg <= 8'h00;
      end
      if (rx_take) rxf_reg <= 1'b1;
      else if (clr_ok && arm_reg[aus_pkg::ST_RXF]) rxf_reg <= 1'b0;
      if (rx_done && rx_accept && rxf_reg) ovr_reg <= 1'b1;
      else if (clr_ok && arm_reg[aus_pkg::ST_OVR]) ovr_reg <= 1'b0;
      if (rx_take && noise_reg | disagree) nf_reg <= 1'b1;
      else if (clr_ok && arm_reg[aus_pkg::ST_NF]) nf_reg <= 1'b0;
      if (rx_take && !rx_stop) fe_reg <= 1'b1;
      else if (clr_ok && arm_reg[aus_pkg::ST_FE]) fe_reg <= 1'b0;
      if (rx_take && rx_par_bad) pe_reg <= 1'b1;
      else if (clr_ok && arm_reg[aus_pkg::ST_PE]) pe_reg <= 1'b0;
      if (idle_evt && idle_arm_reg) idle_reg <= 1'b1;
      else if (clr_ok && arm_reg[aus_pkg::ST_IDLE]) idle_reg <= 1'b0;
      if (rx_take) idle_arm_reg <= 1'b1;
      else if (rx_on_rise || idle_evt || (clr_ok && arm_reg[aus_pkg::ST_IDLE])) begin
        idle_arm_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt requests
  assign tx_irq_req  = module_on &&
                       ((te_reg && ctl_b_reg[aus_pkg::CB_TXE_IE]) ||
                        (tx_done && ctl_b_reg[aus_pkg::CB_TXD_IE]));
  assign rx_irq_req  = !standby &&
                       ((rxf_reg && ctl_b_reg[aus_pkg::CB_RXF_IE]) ||
                        (idle_reg && ctl_b_reg[aus_pkg::CB_IDLE_IE]));
  assign err_irq_req = !standby &&
                       |({ovr_reg, nf_reg, fe_reg, pe_reg} & err_en_reg);

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  a_preamble_high: assert property (@(posedge pclk) disable iff (!presetn)
    tx_state_reg == aus_pkg::TX_PRE |-> txd) else $error("preamble bit low");
  a_break_low: assert property (@(posedge pclk) disable iff (!presetn)
    tx_state_reg == aus_pkg::TX_BRK |-> !txd) else $error("break bit high");
  a_mark_after_brk: assert property (@(posedge pclk) disable iff (!presetn)
    brk_fall |=> brk_tail_reg) else $error("break tail lost");
  a_char_runs_out: assert property (@(posedge pclk) disable iff (!presetn)
    module_on && tx_state_reg == aus_pkg::TX_DATA && tx_bits_reg > 4'h1 ##1 module_on
    |-> tx_state_reg == aus_pkg::TX_DATA) else $error("character cut short");
  a_empty_on_move: assert property (@(posedge pclk) disable iff (!presetn)
    launch_data |=> te_reg && tx_state_reg == aus_pkg::TX_DATA) else $error("empty not set");
  a_done_meaning: assert property (@(posedge pclk) disable iff (!presetn)
    tx_done |-> te_reg && tx_state_reg == aus_pkg::TX_IDLE) else $error("done while busy");
  a_module_off: assert property (@(posedge pclk) disable iff (!presetn)
    !module_on ##1 !module_on |-> te_reg && !tx_irq_req) else $error("module off flags");
  a_overrun_keep: assert property (@(posedge pclk) disable iff (!presetn)
    rx_done && rx_accept && rxf_reg |=> ovr_reg && $stable(rx_buf_reg))
    else $error("overrun handling");
  a_overrun_pend: assert property (@(posedge pclk) disable iff (!presetn)
    rd_data && ovr_reg && !arm_reg[aus_pkg::ST_OVR] |=> ovr_reg) else $error("overrun lost");
  a_idle_armed: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(idle_reg) |-> $past(idle_arm_reg)) else $error("idle without character");
  a_standby_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    standby |-> !rx_irq_req && !err_irq_req) else $error("standby interrupt");

endmodule

/* File: verification/aus_remote_node.sv */
/*
  Remote serial node: drives the receive line of the block with whole frames.
  Assumes it is called just after a rising pclk edge, with bit_cycles equal to
  the bit period programmed in the block.
*/
`timescale 1ns/1ps
module aus_remote_node (
  input  wire logic pclk,
  output logic      rxd
);
  int bit_cycles = 4;

  initial rxd = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // start bit, eight data bits lsb first, then the stop level asked for
  task automatic send_char(input logic [7:0] data, input logic stop);
    logic [9:0] frame;
    frame = {stop, data, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= frame[i];
      repeat (bit_cycles) @(posedge pclk);
    end
    // line back to its idle mark level
    rxd <= 1'b1;
    repeat (bit_cycles) @(posedge pclk);
  endtask
endmodule

/* File: verification/testbench.sv */
/*
  Self-checking bench for the serial control and status block.
  Assumes the remote node model drives rxd and every APB answer comes
  within 50 cycles.
*/
`timescale 1ns/1ps
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr, b, tb;
  logic [8:0]  fr;
  logic [31:0] pwdata, prdata, q;
  logic        rxd, txd, tx_irq_req, rx_irq_req, err_irq_req;
  int          fails, check_count, seed, n;
  int          exp_q[$];

  aus_serial i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .txd(txd), .tx_irq_req(tx_irq_req),
    .rx_irq_req(rx_irq_req), .err_irq_req(err_irq_req));
  aus_remote_node i_node (.pclk(pclk), .rxd(rxd));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (fails == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    check_count++;
    if (got !== ex) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      fails++;
      wrap_up();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd_data();
    apb(1'b0, aus_pkg::OFF_DATA, 32'h0);
    chk("rx data", exp_q.pop_front(), q);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 62860;
    fails = 0;
    check_count = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, aus_pkg::OFF_STAT_A, 32'h0);
    chk("status", 32'hC0, q);
    apb(1'b0, aus_pkg::OFF_CTRL_C, 32'h0);
    chk("ctrl_c", 32'h0, q & 32'h7F);
    apb(1'b0, 8'h20, 32'h0);
    chk("pslverr", 32'h1, {31'h0, e});
    apb(1'b1, aus_pkg::OFF_CTRL_B, 32'h0C);
    apb(1'b0, aus_pkg::OFF_CTRL_B, 32'h0);
    chk("ctrl_b", 32'h0, q);
    apb(1'b1, aus_pkg::OFF_BAUD, 32'h4);
    apb(1'b1, aus_pkg::OFF_CTRL_A, 32'h40);
    apb(1'b1, aus_pkg::OFF_CTRL_C, 32'h08);
    apb(1'b1, aus_pkg::OFF_CTRL_B, 32'h2C);
    tb = 8'($random(seed));
    apb(1'b1, aus_pkg::OFF_DATA, {24'h0, tb});
    // edges since the enabling write took effect
    n = 5;
    while (txd === 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 200) begin
      fails++;
      wrap_up();
    end
    chk("preamble", 32'h1, {31'h0, n >= 39 && n <= 43});
    repeat (5) @(posedge pclk);
    for (int i = 0; i < 9; i++) begin
      fr[i] = txd;
      repeat (4) @(posedge pclk);
    end
    chk("tx frame", {23'h0, 1'b1, tb}, {23'h0, fr});
    apb(1'b0, aus_pkg::OFF_STAT_A, 32'h0);
    chk("tx empty", 32'h1, {31'h0, q[7]});
    b = 8'($random(seed));
    i_node.send_char(b, 1'b1);
    exp_q.push_back(b);
    chk("rx irq", 32'h1, {31'h0, rx_irq_req});
    apb(1'b0, aus_pkg::OFF_STAT_A, 32'h0);
    chk("rx flags", 32'h20, q & 32'h2F);
    apb(1'b0, aus_pkg::OFF_CTRL_C, 32'h0);
    chk("rx ninth", {31'h0, b[7]}, {31'h0, q[7]});
    rd_data();
    // second character of the pair is lost to the overrun
    for (int i = 0; i < 2; i++) begin
      b = 8'($random(seed));
      i_node.send_char(b, 1'b1);
      if (i == 0) exp_q.push_back(b);
    end
    chk("err irq", 32'h1, {31'h0, err_irq_req});
    apb(1'b0, aus_pkg::OFF_STAT_A, 32'h0);
    chk("rx flags", 32'h28, q & 32'h2F);
    rd_data();
    apb(1'b0, aus_pkg::OFF_STAT_A, 32'h0);
    chk("rx flags", 32'h0, q & 32'h2F);
    b = 8'($random(seed));
    i_node.send_char(b, 1'b0);
    exp_q.push_back(b);
    apb(1'b1, aus_pkg::OFF_CTRL_B, 32'h28);
    apb(1'b0, aus_pkg::OFF_STAT_A, 32'h0);
    chk("rx flags", 32'h22, q & 32'h2F);
    rd_data();
    // held break, then its release and the trailing mark bit
    apb(1'b1, aus_pkg::OFF_CTRL_B, 32'h89);
    chk("tx irq", 32'h1, {31'h0, tx_irq_req});
    n = 0;
    repeat (80) begin
      @(posedge pclk);
      if (txd !== 1'b0) n++;
    end
    chk("break low", 32'h0, n);
    apb(1'b1, aus_pkg::OFF_CTRL_B, 32'h88);
    n = 0;
    while (txd !== 1'b1 && n < 60) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 60) begin
      fails++;
      wrap_up();
    end
    repeat (4) @(posedge pclk);
    chk("break tail", 32'h1, {31'h0, txd});
    apb(1'b0, aus_pkg::OFF_STAT_A, 32'h0);
    chk("tx done", 32'hC0, q & 32'hC0);
    apb(1'b1, aus_pkg::OFF_CTRL_B, 32'h80);
    apb(1'b1, aus_pkg::OFF_DATA, 32'h55);
    chk("tx irq", 32'h0, {31'h0, tx_irq_req});
    apb(1'b1, aus_pkg::OFF_CTRL_A, 32'h0);
    apb(1'b0, aus_pkg::OFF_STAT_A, 32'h0);
    chk("module off", 32'hC0, q & 32'hC0);
    chk("tx irq", 32'h0, {31'h0, tx_irq_req});
    wrap_up();
  end
endmodule
